// file: rtl/decim_defs.svh
`ifndef DECIM_DEFS_SVH
`define DECIM_DEFS_SVH

// Clock and timing
`define CLK_PERIOD_NS      25
`define CONV_PERIOD_NS     50
`define CONV_HALF_CLK      1
// Least reset hold, one converter period, rounded up to clk cycles
`define RST_HOLD_CLK       ((`CONV_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Modulator flag delay, 3 1/2 converter periods in clk cycles
`define OVR_DELAY_CLK      7
`define OVR_PIPE_LEN       5

// Mode codes, lowest input range first
`define MODE_CODE_DEC8     2'h0
`define MODE_CODE_DEC2     2'h1
`define MODE_CODE_DEC4     2'h2
`define MODE_CODE_DEC1     2'h3

// Flush lengths in converter samples
`define FLUSH_DEC8         9'h141
`define FLUSH_DEC4         9'h06C
`define FLUSH_DEC2         9'h017
`define FLUSH_DEC1         9'h000

// Data limits
`define DATA_W             16
`define MOD_W              18
`define ACC_W              21
`define FULL_SCALE_POS     18'h07FFF
`define FULL_SCALE_NEG     18'h38000
`define MOD_LIMIT_POS      18'h083D6
`define MOD_LIMIT_NEG      18'h37C2A

`endif

// file: rtl/decim_pkg.sv
`include "decim_defs.svh"

package decim_pkg;

   typedef enum logic [1:0] {
      DEC8 = 2'b00,
      DEC2 = 2'b01,
      DEC4 = 2'b10,
      DEC1 = 2'b11
   } dec_mode_e;

   typedef enum logic [1:0] {
      H_HOLD  = 2'b00,
      H_FLUSH = 2'b01,
      H_RUN   = 2'b10
   } host_state_e;

   typedef logic [`DATA_W-1:0] word_t;
   typedef logic [`MOD_W-1:0]  mod_t;
   typedef logic [`ACC_W-1:0]  acc_t;

endpackage

// file: rtl/conv_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface conv_link_if;
   import decim_pkg::*;

   logic       conv_clk;
   logic       conv_rst_n;
   logic [1:0] mode_sel;
   word_t      data_word;
   logic       data_valid_strobe;
   logic       overrange_flag;

   modport dev (
      output conv_clk,
      input  conv_rst_n,
      input  mode_sel,
      output data_word,
      output data_valid_strobe,
      output overrange_flag
   );

   modport host (
      input  conv_clk,
      output conv_rst_n,
      output mode_sel,
      input  data_word,
      input  data_valid_strobe,
      input  overrange_flag
   );

endinterface

`default_nettype wire

// file: rtl/decim_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "decim_defs.svh"

module decim_ctrl
   import decim_pkg::*;
(
   // Clock, system reset, enable
   input  wire logic   clk,
   input  wire logic   rst_n,
   input  wire logic   ce,
   // Modulator samples
   input  wire logic [`MOD_W-1:0] mod_sample,
   // Link to the receiving logic
   conv_link_if.dev    link
);

   // Divider and modulator side, cleared by the converter reset
   typedef struct packed {
      logic                      run;
      logic [3:0]                cnt;
      logic                      samp_ov;
      logic [`OVR_PIPE_LEN-1:0]  ov_pipe;
      logic                      ov_stage;
      logic                      ovr;
   } ctrl_s;

   // Converter clock, mode latch and filter storage
   typedef struct packed {
      logic      ph;
      dec_mode_e mode;
      acc_t      acc;
      word_t     word_pend;
      logic      stage_ov_pend;
      word_t     data;
   } filt_s;

   localparam ctrl_s CTRL_RST = '0;
   localparam filt_s FILT_RST = '{ph: 1'b0, mode: DEC8, acc: '0, word_pend: '0,
                                  stage_ov_pend: 1'b0, data: '0};

   ctrl_s ctrl_reg;
   ctrl_s ctrl_next;
   filt_s filt_reg;
   filt_s filt_next;

   logic              rise_ev;
   logic              fall_ev;
   logic [4:0]        period_clk;
   logic [1:0]        shift_amt;
   mod_t              clipped;
   logic              mod_ov;
   acc_t              acc_sum;
   acc_t              acc_avg;
   logic              stage_ov;
   word_t             stage_word;
   logic              last_samp;
   logic              wrap;

   // Ratio of each mode as clk cycles per word and average shift
   function automatic logic [4:0] period_of(input dec_mode_e m);
      unique case (m)
         DEC8:    period_of = 5'h10;
         DEC4:    period_of = 5'h08;
         DEC2:    period_of = 5'h04;
         DEC1:    period_of = 5'h02;
      endcase
   endfunction

   function automatic logic [1:0] shift_of(input dec_mode_e m);
      unique case (m)
         DEC8:    shift_of = 2'h3;
         DEC4:    shift_of = 2'h2;
         DEC2:    shift_of = 2'h1;
         DEC1:    shift_of = 2'h0;
      endcase
   endfunction

   // Converter clock edges as seen one cycle ahead
   assign rise_ev = ~filt_reg.ph;
   assign fall_ev = filt_reg.ph;
   assign period_clk = period_of(filt_reg.mode);
   assign shift_amt = shift_of(filt_reg.mode);

   // Modulator detector with 3% headroom clip
   always_comb begin
      mod_ov = 1'b0;
      clipped = mod_sample;
      if ($signed(mod_sample) > $signed(`MOD_LIMIT_POS)) begin
         mod_ov = 1'b1;
         clipped = `MOD_LIMIT_POS;
      end else if ($signed(mod_sample) < $signed(`MOD_LIMIT_NEG)) begin
         mod_ov = 1'b1;
         clipped = `MOD_LIMIT_NEG;
      end
   end

   // Averaging stand-in for the half-band chain
   assign last_samp = rise_ev && (ctrl_reg.cnt == 4'(period_clk - 5'h02));
   assign acc_sum = (ctrl_reg.cnt == 4'h0) ? acc_t'($signed(clipped))
                  : acc_t'($signed(filt_reg.acc) + $signed(clipped));
   assign acc_avg = acc_t'($signed(acc_sum) >>> shift_amt);

   // Stage three detector, hard limit at full scale
   always_comb begin
      stage_ov = 1'b0;
      stage_word = acc_avg[`DATA_W-1:0];
      if ($signed(acc_avg) > $signed(`FULL_SCALE_POS)) begin
         stage_ov = 1'b1;
         stage_word = 16'h7FFF;
      end else if ($signed(acc_avg) < $signed(`FULL_SCALE_NEG)) begin
         stage_ov = 1'b1;
         stage_word = 16'h8000;
      end
   end

   // Divider wraps once per output word
   assign wrap = ctrl_reg.run && (ctrl_reg.cnt >= 4'(period_clk - 5'h01));

   // Next state of the divider and detector pipeline
   always_comb begin
      ctrl_next = ctrl_reg;
      if (ce) begin
         // Start only on a falling converter edge after release
         if (!ctrl_reg.run && fall_ev) begin
            ctrl_next.run = 1'b1;
            ctrl_next.cnt = 4'h0;
         end else if (ctrl_reg.run) begin
            ctrl_next.cnt = wrap ? 4'h0 : ctrl_reg.cnt + 4'h1;
         end
         // Modulator flag captured at the sampling edge
         if (rise_ev) begin
            ctrl_next.samp_ov = mod_ov;
         end
         ctrl_next.ov_pipe = {ctrl_reg.ov_pipe[`OVR_PIPE_LEN-2:0], ctrl_reg.samp_ov};
         if (ctrl_reg.run && last_samp) begin
            ctrl_next.ov_stage = stage_ov;
         end
         // Re-evaluated every cycle, so also every converter period
         ctrl_next.ovr = ctrl_reg.ov_pipe[`OVR_PIPE_LEN-1] | ctrl_reg.ov_stage;
      end
   end

   // Next state of converter clock, mode latch and filter
   always_comb begin
      filt_next = filt_reg;
      if (ce) begin
         filt_next.ph = ~filt_reg.ph;
         // Mode pin sampled only on the falling converter edge
         if (fall_ev) begin
            filt_next.mode = dec_mode_e'(link.mode_sel);
         end
         // Filter clock is gated by the divider run bit
         if (ctrl_reg.run && rise_ev) begin
            filt_next.acc = acc_sum;
         end
         if (ctrl_reg.run && last_samp) begin
            filt_next.word_pend = stage_word;
         end
         // Word changes together with the strobe rising
         if (wrap) begin
            filt_next.data = filt_reg.word_pend;
         end
      end
   end

   // Divider side clears at once on converter reset
   always_ff @(posedge clk or negedge link.conv_rst_n) begin
      if (!link.conv_rst_n) begin
         ctrl_reg <= CTRL_RST;
      end else if (!rst_n) begin
         ctrl_reg <= CTRL_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Filter storage ignores the converter reset on purpose
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         filt_reg <= FILT_RST;
      end else begin
         filt_reg <= filt_next;
      end
   end

   // Strobe about half duty; low while reset holds the divider
   assign link.data_valid_strobe = ctrl_reg.run
                                 && ({1'b0, ctrl_reg.cnt} < (period_clk >> 1));
   assign link.data_word = filt_reg.data;
   assign link.overrange_flag = ctrl_reg.ovr;
   assign link.conv_clk = filt_reg.ph;

endmodule

`default_nettype wire

// file: rtl/decim_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "decim_defs.svh"

module decim_host
   import decim_pkg::*;
(
   // Clock, system reset, enable
   input  wire logic   clk,
   input  wire logic   rst_n,
   input  wire logic   ce,
   // User control
   input  wire logic   reset_req,
   input  wire logic [1:0] mode_req,
   // Captured results
   output logic [`DATA_W-1:0] word_out,
   output logic       word_valid,
   output logic       ovr_out,
   output logic       flushing,
   // Link to the converter
   conv_link_if.host   link
);

   typedef struct packed {
      host_state_e state;
      logic [1:0]  hold_cnt;
      logic [8:0]  flush_cnt;
      logic [1:0]  mode;
      logic        rst_out_n;
      logic        ph_d;
      logic        dv_d;
      word_t       word;
      logic        valid;
      logic        ovr;
   } host_s;

   localparam host_s HOST_RST = '{state: H_HOLD, hold_cnt: 2'h0, flush_cnt: 9'h000,
                                  mode: `MODE_CODE_DEC8, rst_out_n: 1'b0, ph_d: 1'b0,
                                  dv_d: 1'b0, word: '0, valid: 1'b0, ovr: 1'b0};

   host_s       st_reg;
   host_s       st_next;
   logic        conv_fall;
   logic [8:0]  flush_len;

   // Samples to discard for the mode in force
   always_comb begin
      unique case (st_reg.mode)
         `MODE_CODE_DEC8: flush_len = `FLUSH_DEC8;
         `MODE_CODE_DEC4: flush_len = `FLUSH_DEC4;
         `MODE_CODE_DEC2: flush_len = `FLUSH_DEC2;
         `MODE_CODE_DEC1: flush_len = `FLUSH_DEC1;
      endcase
   end

   assign conv_fall = st_reg.ph_d && !link.conv_clk;

   // Reset pulse, flush count, then capture
   always_comb begin
      st_next = st_reg;
      if (ce) begin
         st_next.ph_d = link.conv_clk;
         st_next.dv_d = link.data_valid_strobe;
         st_next.valid = 1'b0;
         // Overrange is only stable while the converter clock is low
         if (conv_fall) begin
            st_next.ovr = link.overrange_flag;
         end
         unique case (st_reg.state)
            H_HOLD: begin
               st_next.rst_out_n = 1'b0;
               st_next.mode = mode_req;
               if (st_reg.hold_cnt >= 2'(`RST_HOLD_CLK)) begin
                  st_next.state = H_FLUSH;
                  st_next.rst_out_n = 1'b1;
                  st_next.flush_cnt = 9'h000;
               end else begin
                  st_next.hold_cnt = st_reg.hold_cnt + 2'h1;
               end
            end
            H_FLUSH: begin
               if (st_reg.flush_cnt >= flush_len) begin
                  st_next.state = H_RUN;
               end else if (conv_fall) begin
                  st_next.flush_cnt = st_reg.flush_cnt + 9'h001;
               end
            end
            H_RUN: begin
               // Data changes with the strobe, so take it once high
               if (link.data_valid_strobe && !st_reg.dv_d) begin
                  st_next.word = link.data_word;
                  st_next.valid = 1'b1;
               end
            end
            default: begin
               st_next.state = H_HOLD;
            end
         endcase
         // A new mode needs a fresh reset and flush
         if (reset_req || (mode_req != st_reg.mode && st_reg.state != H_HOLD)) begin
            st_next.state = H_HOLD;
            st_next.hold_cnt = 2'h0;
            st_next.rst_out_n = 1'b0;
            // No word may come out once the flush has restarted
            st_next.valid = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= HOST_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign link.conv_rst_n = st_reg.rst_out_n;
   assign link.mode_sel = st_reg.mode;
   assign word_out = st_reg.word;
   assign word_valid = st_reg.valid;
   assign ovr_out = st_reg.ovr;
   assign flushing = (st_reg.state != H_RUN);

endmodule

`default_nettype wire

// file: tb/decim_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "decim_defs.svh"

module decim_link_sva
   import decim_pkg::*;
(
   // Clock and system reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Link signals
   input wire logic        conv_clk,
   input wire logic        conv_rst_n,
   input wire logic [1:0]  mode_sel,
   input wire word_t       data_word,
   input wire logic        data_valid_strobe,
   input wire logic        overrange_flag,
   // Modulator samples
   input wire logic [17:0] mod_sample
);
   logic mod_over;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Beyond the modulator limit either way
   assign mod_over = ($signed(mod_sample) > $signed(`MOD_LIMIT_POS))
                  || ($signed(mod_sample) < $signed(`MOD_LIMIT_NEG));

   // One word period per ratio, strobe high half then low half
   sequence s_word8;
      data_valid_strobe [*8] ##1 !data_valid_strobe [*8] ##1 data_valid_strobe;
   endsequence
   sequence s_word4;
      data_valid_strobe [*4] ##1 !data_valid_strobe [*4] ##1 data_valid_strobe;
   endsequence
   sequence s_word2;
      data_valid_strobe [*2] ##1 !data_valid_strobe [*2] ##1 data_valid_strobe;
   endsequence
   sequence s_word1;
      data_valid_strobe ##1 !data_valid_strobe ##1 data_valid_strobe;
   endsequence
   // Dividers idle at release, first strobe soon after
   sequence s_start;
      !data_valid_strobe ##[1:3] data_valid_strobe;
   endsequence

   chk_rst_strobe: assert property (!conv_rst_n |-> !data_valid_strobe)
      else $error("strobe high in converter reset");
   chk_rst_flag: assert property (!conv_rst_n |-> !overrange_flag)
      else $error("flag high in converter reset");
   chk_rst_hold: assert property ($fell(conv_rst_n) |-> !conv_rst_n [*2])
      else $error("converter reset pulse too short");
   chk_div_start: assert property ($rose(conv_rst_n) |-> s_start)
      else $error("dividers did not restart in time");
   chk_data_strobe: assert property (!$stable(data_word) |-> $rose(data_valid_strobe))
      else $error("word changed without strobe rise");
   chk_period_dec8: assert property (disable iff (!rst_n || !conv_rst_n)
      $rose(data_valid_strobe) && mode_sel == `MODE_CODE_DEC8 |-> s_word8)
      else $error("bad word period, ratio 8");
   chk_period_dec2: assert property (disable iff (!rst_n || !conv_rst_n)
      $rose(data_valid_strobe) && mode_sel == `MODE_CODE_DEC2 |-> s_word2)
      else $error("bad word period, ratio 2");
   chk_period_dec4: assert property (disable iff (!rst_n || !conv_rst_n)
      $rose(data_valid_strobe) && mode_sel == `MODE_CODE_DEC4 |-> s_word4)
      else $error("bad word period, ratio 4");
   chk_period_dec1: assert property (disable iff (!rst_n || !conv_rst_n)
      $rose(data_valid_strobe) && mode_sel == `MODE_CODE_DEC1 |-> s_word1)
      else $error("bad word period, ratio 1");
   // Only samples taken well after release count, the pipe restarts
   chk_ovr_delay: assert property (disable iff (!rst_n || !conv_rst_n)
      !conv_clk && mod_over && $past(conv_rst_n, 3) |-> ##[7:8] overrange_flag)
      else $error("modulator overrange flag late");
endmodule

`default_nettype wire

// file: tb/decimator_reset_overrange_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "decim_defs.svh"

module decimator_reset_overrange_ctrl_tb
   import decim_pkg::*;
;
   logic        clk;
   logic        rst_n;
   logic        ce;
   logic [17:0] mod_sample;
   logic        reset_req;
   logic [1:0]  mode_req;
   word_t       word_out;
   logic        word_valid;
   logic        ovr_out;
   logic        flushing;
   int          num_errors = 0;
   int          compares = 0;
   int          wait_cnt;
   integer      seed;
   logic [15:0] r;
   logic [16:0] note;
   logic [16:0] exp_q[$];
   logic [17:0] samp_tab[5] = '{18'h0, 18'h0, 18'h080E8, 18'h09C40, 18'h363C0};
   logic [16:0] want_tab[5] = '{17'h0, 17'h0, 17'h17FFF, 17'h17FFF, 17'h18000};
   logic [8:0]  flush_tab[4] = '{`FLUSH_DEC8, `FLUSH_DEC2, `FLUSH_DEC4, `FLUSH_DEC1};

   conv_link_if link_if ();

   decim_ctrl decim_ctrl_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
      .mod_sample(mod_sample), .link(link_if.dev));

   decim_host decim_host_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .reset_req(reset_req),
      .mode_req(mode_req), .word_out(word_out), .word_valid(word_valid), .ovr_out(ovr_out),
      .flushing(flushing), .link(link_if.host));

   decim_link_sva decim_link_sva_inst (.clk(clk), .rst_n(rst_n),
      .conv_clk(link_if.conv_clk), .conv_rst_n(link_if.conv_rst_n),
      .mode_sel(link_if.mode_sel), .data_word(link_if.data_word),
      .data_valid_strobe(link_if.data_valid_strobe),
      .overrange_flag(link_if.overrange_flag), .mod_sample(mod_sample));

   // 40 MHz system clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("Compares %0d, errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Bounded wait for the next captured word, cycles waited in wait_cnt
   task automatic wait_word(input int limit);
      wait_cnt = 0;
      @(negedge clk);
      while (word_valid !== 1'b1 && wait_cnt < limit) begin
         @(negedge clk);
         wait_cnt++;
      end
      // A word on the very last allowed cycle still counts as arrived
      if (word_valid !== 1'b1) begin
         num_errors++;
         $display("Error at %0t: no word arrived", $time);
         wrap_up();
      end
   endtask

   // Scoreboard: each captured word against the oldest note, when one is queued
   always @(negedge clk) begin
      if (word_valid === 1'b1) begin
         check({16'h0, flushing}, 17'h0);
         if (exp_q.size() > 0) begin
            note = exp_q.pop_front();
            check({ovr_out, word_out}, note);
         end
      end
   end

   // Every mode: restart, time the flush, then in-range and overrange levels
   initial begin
      seed = 32'h99B3;
      rst_n = 1'b0;
      ce = 1'b1;
      mod_sample = 18'h00000;
      reset_req = 1'b0;
      mode_req = 2'h0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      for (int m = 0; m < 4; m++) begin
         @(negedge clk);
         mode_req = m[1:0];
         reset_req = 1'b1;
         @(negedge clk);
         reset_req = 1'b0;
         wait_word(3000);
         // Lower bound from the flush length, upper allows hold plus one word
         check({15'h0, wait_cnt + 1 >= 2 * flush_tab[m],
                wait_cnt <= 2 * flush_tab[m] + 24}, 17'h3);
         for (int v = 0; v < 5; v++) begin
            if (v < 2) begin
               r = 16'($random(seed));
               samp_tab[v] = {{2{r[15]}}, r};
               want_tab[v] = {1'b0, r};
            end
            @(negedge clk);
            mod_sample = samp_tab[v];
            // Settle filter and flag pipes before noting results
            repeat (6) wait_word(100);
            @(posedge clk);
            repeat (3) exp_q.push_back(want_tab[v]);
            wait_cnt = 0;
            while (exp_q.size() > 0 && wait_cnt < 100) begin
               @(negedge clk);
               wait_cnt++;
            end
            if (exp_q.size() > 0) begin
               num_errors++;
               $display("Error at %0t: noted words never captured", $time);
               wrap_up();
            end
         end
      end
      wrap_up();
   end

   // Watchdog, far beyond the expected run of under 10000 cycles
   initial begin
      #(60000 * 25);
      num_errors++;
      $display("Error at %0t: watchdog expired", $time);
      wrap_up();
   end
endmodule

`default_nettype wire
